// *** socket_force_pkg.sv ***
package socket_force_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] EVENT_REG_OFFSET = 8'h00;
  localparam logic [7:0] PRESENT_REG_OFFSET = 8'h08;
  localparam logic [7:0] INJECT_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h40;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h44;
  localparam logic [7:0] STATE_OFFSET = 8'h48;
  // force register field positions
  localparam int REINTERROGATE_BIT = 14;
  localparam int VOLT_HI_BIT = 13;
  localparam int VOLT_LO_BIT = 10;
  localparam int PRESENT_HI_BIT = 13;
  localparam int PRESENT_MID_BIT = 7;
  localparam int CARD_TYPE_HI_BIT = 5;
  localparam int CARD_TYPE_LO_BIT = 4;
  localparam int EVENT_HI_BIT = 3;
  // present-state target order: 0 sixteen-bit, 1 cardbus, 2 unknown, 3 loss,
  // 4 invalid supply, 5 five volt, 6 three volt, 7 xx volt, 8 yy volt
  localparam int PRESENT_N = 9;
  // event target order: 0 status change, 1 detect one, 2 detect two, 3 power cycle
  localparam int EVENT_N = 4;
  // interrupt status and mask layout
  localparam int IRQ_N = 4;
  localparam int IRQ_PRESENT_FORCED = 0;
  localparam int IRQ_EVENT_FORCED = 1;
  localparam int IRQ_POWER_DISABLED = 2;
  localparam int IRQ_INTERROGATED = 3;
  localparam logic [IRQ_N-1:0] IRQ_MASK_RESET = 4'h0;
  // state register layout
  localparam int STATE_POWER_EN = 0;
  localparam int STATE_BUSY = 1;
  localparam int STATE_PME = 2;
  localparam logic POWER_EN_RESET = 1'b1;
  localparam logic PIN_RESET_VALUE = 1'b0;
  typedef enum logic [1:0] {
    IQ_IDLE = 2'b00,
    IQ_START = 2'b01,
    IQ_WAIT = 2'b10
  } interrogate_state_t;
endpackage

// *** pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;
  logic level_reg;

  // stage1 only feeds stage2; the filter looks at stages 2 and 3
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= RESET_VALUE;
      stage2_reg <= RESET_VALUE;
      stage3_reg <= RESET_VALUE;
    end else begin
      stage1_reg <= pin;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a change counts only once two settled stages agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= RESET_VALUE;
    end else if (stage2_reg == stage3_reg) begin
      level_reg <= stage3_reg;
    end
  end

  assign level = level_reg;
endmodule // pin_sync

// *** socket_force_event_logic.sv ***
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module socket_force_event_logic (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [socket_force_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rdata,
  input wire logic global_reset_in,
  input wire logic bus_reset_in,
  input wire logic pme_enable,
  input wire logic interrogate_done,
  output logic [socket_force_pkg::PRESENT_N-1:0] present_force_strobe,
  output logic [socket_force_pkg::PRESENT_N-1:0] present_force_value,
  output logic [socket_force_pkg::EVENT_N-1:0] event_force_strobe,
  output logic [socket_force_pkg::EVENT_N-1:0] event_force_value,
  output logic interrogate_start,
  output logic power_control_enable,
  output logic context_clear,
  output logic irq
);

  localparam int PN = socket_force_pkg::PRESENT_N;
  localparam int EN = socket_force_pkg::EVENT_N;
  localparam int IN = socket_force_pkg::IRQ_N;

  // flags bound for the present-state register, in target order
  function automatic logic [PN-1:0] present_field(input logic [31:0] data);
    present_field = {data[socket_force_pkg::PRESENT_HI_BIT:socket_force_pkg::PRESENT_MID_BIT],
                     data[socket_force_pkg::CARD_TYPE_HI_BIT:socket_force_pkg::CARD_TYPE_LO_BIT]};
  endfunction

  // flags bound for the event register, in target order
  function automatic logic [EN-1:0] event_field(input logic [31:0] data);
    event_field = data[socket_force_pkg::EVENT_HI_BIT:0];
  endfunction

  // any forced voltage capability written as one
  function automatic logic volt_forced(input logic [31:0] data);
    volt_forced = |data[socket_force_pkg::VOLT_HI_BIT:socket_force_pkg::VOLT_LO_BIT];
  endfunction

  function automatic logic hit(input logic [socket_force_pkg::ADDR_W-1:0] a,
                               input logic [7:0] offset);
    hit = (a == offset);
  endfunction

  logic global_level;
  logic bus_level;
  logic inject_write;
  logic status_read;
  logic mask_write;
  logic trigger;
  logic context_clear_reg;
  logic [PN-1:0] present_bits;
  logic [EN-1:0] event_bits;
  logic [PN-1:0] present_strobe_reg;
  logic [socket_force_pkg::VOLT_HI_BIT-socket_force_pkg::VOLT_LO_BIT:0] volt_value_reg;
  logic invalid_supply_value_reg;
  logic [1:0] loss_unknown_value_reg;
  logic [1:0] card_type_value_reg;
  logic [EN-1:0] event_strobe_reg;
  logic power_event_value_reg;
  logic detect_two_value_reg;
  logic detect_one_value_reg;
  logic status_event_value_reg;
  logic power_enable_reg;
  logic start_reg;
  logic interrogated;
  socket_force_pkg::interrogate_state_t state_reg;
  socket_force_pkg::interrogate_state_t state_next;
  logic [IN-1:0] status_reg;
  logic [IN-1:0] status_next;
  logic [IN-1:0] status_set;
  logic [IN-1:0] mask_reg;
  logic irq_reg;
  logic [31:0] read_value;
  logic [31:0] rdata_reg;

  // reset pins come from outside the clock domain
  pin_sync #(
    .RESET_VALUE(socket_force_pkg::PIN_RESET_VALUE)
  ) global_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(global_reset_in),
    .level(global_level)
  );

  pin_sync #(
    .RESET_VALUE(socket_force_pkg::PIN_RESET_VALUE)
  ) bus_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(bus_reset_in),
    .level(bus_level)
  );

  assign inject_write = wr_strobe && hit(addr, socket_force_pkg::INJECT_OFFSET);
  assign status_read = rd_strobe && hit(addr, socket_force_pkg::IRQ_STATUS_OFFSET);
  assign mask_write = wr_strobe && hit(addr, socket_force_pkg::IRQ_MASK_OFFSET);
  assign trigger = inject_write && wdata[socket_force_pkg::REINTERROGATE_BIT];
  assign interrogated = (state_reg == socket_force_pkg::IQ_WAIT) && interrogate_done;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      context_clear_reg <= 1'b0;
    end else begin
      context_clear_reg <= global_level || (bus_level && !pme_enable);
    end
  end

  // fields split here so each target block picks only its own bits; power and status logic decode wdata again
  assign present_bits = present_field(wdata);
  assign event_bits = event_field(wdata);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      present_strobe_reg <= '0;
    end else begin
      present_strobe_reg <= {PN{inject_write}};
    end
  end

  // event strobes keep pace with the present-state strobes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      event_strobe_reg <= '0;
    end else begin
      event_strobe_reg <= {EN{inject_write}};
    end
  end

  // voltage flags
  // values are held only to keep outputs on flip-flops; the strobe says when they count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      volt_value_reg <= '0;
    end else if (inject_write) begin
      volt_value_reg <= present_bits[PN-1:5];
    end
  end

  // invalid supply request takes the written value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      invalid_supply_value_reg <= 1'b0;
    end else if (inject_write) begin
      invalid_supply_value_reg <= present_bits[4];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loss_unknown_value_reg <= '0;
    end else if (inject_write) begin
      loss_unknown_value_reg <= present_bits[3:2];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      card_type_value_reg <= '0;
    end else if (inject_write) begin
      card_type_value_reg <= present_bits[1:0];
    end
  end

  // power cycle event only; the powered state has no path from here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_event_value_reg <= 1'b0;
    end else if (inject_write) begin
      power_event_value_reg <= event_bits[3];
    end
  end

  // second detect event; live detect state untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      detect_two_value_reg <= 1'b0;
    end else if (inject_write) begin
      detect_two_value_reg <= event_bits[2];
    end
  end

  // first detect event; live detect state untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      detect_one_value_reg <= 1'b0;
    end else if (inject_write) begin
      detect_one_value_reg <= event_bits[1];
    end
  end

  // status change event; live status untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_event_value_reg <= 1'b0;
    end else if (inject_write) begin
      status_event_value_reg <= event_bits[0];
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      socket_force_pkg::IQ_IDLE: begin
        if (trigger) begin
          state_next = socket_force_pkg::IQ_START;
        end
      end
      socket_force_pkg::IQ_START: begin
        state_next = socket_force_pkg::IQ_WAIT;
      end
      socket_force_pkg::IQ_WAIT: begin
        if (interrogate_done) begin
          state_next = socket_force_pkg::IQ_IDLE;
        end
      end
      default: begin
        state_next = socket_force_pkg::IQ_IDLE;
      end
    endcase
  end

  // a context reset abandons an interrogation in progress
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= socket_force_pkg::IQ_IDLE;
    end else if (context_clear_reg) begin
      state_reg <= socket_force_pkg::IQ_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // start pulse to the interrogation logic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= !context_clear_reg && (state_next == socket_force_pkg::IQ_START)
                   && (state_reg == socket_force_pkg::IQ_IDLE);
    end
  end

  // forced voltage disables power control
  // a new force wins over a completing interrogation, since it is the later intent
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_enable_reg <= socket_force_pkg::POWER_EN_RESET;
    end else if (context_clear_reg) begin
      power_enable_reg <= socket_force_pkg::POWER_EN_RESET;
    end else if (inject_write && volt_forced(wdata)) begin
      power_enable_reg <= 1'b0;
    end else if (interrogated) begin
      power_enable_reg <= 1'b1;
    end
  end

  // sticky interrupt events
  always_comb begin
    status_set = '0;
    status_set[socket_force_pkg::IRQ_PRESENT_FORCED] = inject_write;
    status_set[socket_force_pkg::IRQ_EVENT_FORCED] = inject_write && |event_field(wdata);
    status_set[socket_force_pkg::IRQ_POWER_DISABLED] = inject_write && volt_forced(wdata);
    status_set[socket_force_pkg::IRQ_INTERROGATED] = interrogated;
    // set wins over the read that clears
    status_next = (status_read ? '0 : status_reg) | status_set;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= socket_force_pkg::IRQ_MASK_RESET;
    end else if (mask_write) begin
      mask_reg <= wdata[IN-1:0];
    end
  end

  // level output lags the status by one cycle to stay on a flip-flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // read mux; the force register is write-only and reads as zero
  always_comb begin
    read_value = '0;
    case (addr)
      socket_force_pkg::INJECT_OFFSET: begin
        // reserved and write-only bits read zero
        read_value = '0;
      end
      socket_force_pkg::IRQ_STATUS_OFFSET: begin
        read_value[IN-1:0] = status_reg;
      end
      socket_force_pkg::IRQ_MASK_OFFSET: begin
        read_value[IN-1:0] = mask_reg;
      end
      socket_force_pkg::STATE_OFFSET: begin
        read_value[socket_force_pkg::STATE_POWER_EN] = power_enable_reg;
        read_value[socket_force_pkg::STATE_BUSY] = (state_reg != socket_force_pkg::IQ_IDLE);
        read_value[socket_force_pkg::STATE_PME] = pme_enable;
      end
      default: begin
        read_value = '0;
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (rd_strobe) begin
      rdata_reg <= read_value;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata = rdata_reg;
  assign present_force_strobe = present_strobe_reg;
  assign present_force_value = {volt_value_reg, invalid_supply_value_reg, loss_unknown_value_reg, card_type_value_reg};
  assign event_force_strobe = event_strobe_reg;
  assign event_force_value = {power_event_value_reg, detect_two_value_reg, detect_one_value_reg,
                              status_event_value_reg};
  assign interrogate_start = start_reg;
  assign power_control_enable = power_enable_reg;
  assign context_clear = context_clear_reg;
  assign irq = irq_reg;

endmodule // socket_force_event_logic

// *** socket_force_event_monitor.sv ***
`timescale 1ns/1ps
module socket_force_event_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [socket_force_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [31:0] rdata,
  input wire logic interrogate_done,
  input wire logic [socket_force_pkg::PRESENT_N-1:0] present_force_strobe,
  input wire logic [socket_force_pkg::PRESENT_N-1:0] present_force_value,
  input wire logic [socket_force_pkg::EVENT_N-1:0] event_force_strobe,
  input wire logic [socket_force_pkg::EVENT_N-1:0] event_force_value,
  input wire logic interrogate_start,
  input wire logic power_control_enable,
  input wire logic context_clear
);
  logic hit;
  assign hit = wr_strobe && addr == socket_force_pkg::INJECT_OFFSET;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_strobe_all_bits: assert property (hit |=> present_force_strobe == 9'h1FF && event_force_strobe == 4'hF)
    else $error("force strobes missing");
  a_no_stray_strobe: assert property (!hit |=> present_force_strobe == 9'h0 && event_force_strobe == 4'h0)
    else $error("force strobe without write");
  a_present_value_map: assert property (hit |=> present_force_value == $past({wdata[13:7], wdata[5:4]}))
    else $error("present value mismatch");
  a_event_value_map: assert property (hit |=> event_force_value == $past(wdata[3:0]))
    else $error("event value mismatch");
  a_volt_disables_power: assert property (hit && |wdata[13:10] |=>
    $past(context_clear) || !power_control_enable)
    else $error("power control still enabled");
  a_start_from_write: assert property (interrogate_start |-> $past(hit && wdata[14]))
    else $error("interrogation start without cause");
  a_power_regain_cause: assert property ($rose(power_control_enable) |->
    $past(interrogate_done) || $past(context_clear))
    else $error("power control enabled without cause");
  a_force_reads_zero: assert property (rd_strobe && addr == socket_force_pkg::INJECT_OFFSET |=> rdata == 32'h0)
    else $error("force register read nonzero");
  a_context_power_on: assert property (context_clear [*2] |-> power_control_enable)
    else $error("context clear left power disabled");
endmodule // socket_force_event_monitor

bind socket_force_event_logic socket_force_event_monitor mon_u (.clock(clock), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .interrogate_done(interrogate_done),
  .present_force_strobe(present_force_strobe), .present_force_value(present_force_value),
  .event_force_strobe(event_force_strobe), .event_force_value(event_force_value),
  .interrogate_start(interrogate_start), .power_control_enable(power_control_enable), .context_clear(context_clear));

// *** socket_force_event_logic_tb.sv ***
`timescale 1ns/1ps
module socket_force_event_logic_tb;
  logic clock = 1'b0, rst_n = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0, interrogate_done = 1'b0;
  logic global_reset_in = 1'b0, bus_reset_in = 1'b0, pme_enable = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [8:0] p_stb, p_val;
  logic [3:0] e_stb, e_val;
  logic start, pwr_en, ctx_clr, irq;
  int mismatches = 0, checked = 0;
  always #5 clock = ~clock;
  socket_force_event_logic dut_u (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .global_reset_in(global_reset_in), .bus_reset_in(bus_reset_in),
    .pme_enable(pme_enable), .interrogate_done(interrogate_done), .present_force_strobe(p_stb),
    .present_force_value(p_val), .event_force_strobe(e_stb), .event_force_value(e_val),
    .interrogate_start(start), .power_control_enable(pwr_en), .context_clear(ctx_clr), .irq(irq));
  task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) wr_strobe <= 1'b1; addr <= a; wdata <= d;
    @(posedge clock) wr_strobe <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock) rd_strobe <= 1'b1; addr <= a;
    @(posedge clock) rd_strobe <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task tick;
    @(posedge clock) #1;
  endtask
  task done_pulse;
    @(posedge clock) interrogate_done <= 1'b1;
    @(posedge clock) interrogate_done <= 1'b0;
    #1;
  endtask
  // async entry, so a second reset can land mid-run
  task do_reset;
    @(posedge clock) rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    tick;
    chk({start, pwr_en, ctx_clr, irq, p_stb, e_stb}, {4'b0100, 13'h0});
  endtask
  task t_bits;
    logic [31:0] d;
    for (int i = 0; i < 32; i++) begin
      d = 32'h1 << i;
      wr(8'h0C, d);
      chk({p_stb, e_stb, p_val, e_val}, {13'h1FFF, d[13:7], d[5:4], d[3:0]});
    end
    tick;
    chk({p_stb, e_stb}, 13'h0);
    chk(pwr_en, 1'b0);
    done_pulse;
    chk(pwr_en, 1'b1);
  endtask
  task t_interrogate;
    wr(8'h0C, 32'h0000_4C05);
    chk(pwr_en, 1'b0);
    chk(start, 1'b1);
    tick;
    chk(start, 1'b0);
    wr(8'h0C, 32'h0000_4000);
    chk(start, 1'b0);
    done_pulse;
    chk(pwr_en, 1'b1);
  endtask
  task t_irq;
    wr(8'h44, 32'hF);
    tick;
    chk(irq, 1'b1);
    rd(8'h40, 32'hF);
    tick;
    chk(irq, 1'b0);
    wr(8'h44, 32'h0);
    wr(8'h0C, 32'h1);
    tick;
    chk(irq, 1'b0);
    wr(8'h44, 32'h1);
    tick;
    chk(irq, 1'b1);
    rd(8'h40, 32'h3);
    tick;
    chk(irq, 1'b0);
  endtask
  task t_regs;
    rd(8'h0C, 32'h0);
    rd(8'h80, 32'h0);
    wr(8'h48, 32'h0);
    rd(8'h48, 32'h1);
  endtask
  task wait_ctx(input logic v);
    int n;
    n = 0;
    while (ctx_clr !== v && n < 20) begin
      tick;
      n++;
    end
    checked++;
    if (ctx_clr !== v) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, ctx_clr, v);
      tally_and_finish;
    end
  endtask
  // bus reset must spare context flags while pme is enabled
  task t_context;
    wr(8'h0C, 32'h0000_0400);
    @(posedge clock) pme_enable <= 1'b1; bus_reset_in <= 1'b1;
    repeat (10) tick;
    chk({ctx_clr, pwr_en}, 2'b00);
    rd(8'h48, 32'h4);
    @(posedge clock) global_reset_in <= 1'b1;
    wait_ctx(1'b1);
    tick;
    chk(pwr_en, 1'b1);
    @(posedge clock) global_reset_in <= 1'b0; bus_reset_in <= 1'b0;
    wait_ctx(1'b0);
    @(posedge clock) pme_enable <= 1'b0; bus_reset_in <= 1'b1;
    wait_ctx(1'b1);
    @(posedge clock) bus_reset_in <= 1'b0;
    wait_ctx(1'b0);
  endtask
  initial begin
    do_reset;
    t_bits;
    t_interrogate;
    t_irq;
    t_regs;
    t_context;
    do_reset;
    tally_and_finish;
  end
endmodule // socket_force_event_logic_tb
